// ---- design/cls_pkg.sv ----
// Purpose: shared constants of the card status register block
// Assumes: one 8-bit special-function register space
// Notes: the register address, bit positions and response lengths live here
package cls_pkg;
  // special-function address of the status register
  localparam logic [7:0] STATUS_ADDR = 8'h00_DE;
  // status reset value, reserved bits 7:6 stay zero
  localparam logic [7:0] STATUS_RESET = 8'h00_00;
  // field positions inside the status register
  localparam int BIT_FIFO_LOCK = 0;
  localparam int BIT_RESP_FMT = 1;
  localparam int BIT_RESP_CRC = 2;
  localparam int BIT_DATA_FMT = 3;
  localparam int BIT_DATA_CRC = 4;
  localparam int BIT_BUSY = 5;
  // response lengths in bits
  localparam logic [7:0] RESP_LEN_SHORT = 8'h00_30;
  localparam logic [7:0] RESP_LEN_LONG = 8'h00_88;
  // first bit covered by the check sequence in a long response
  localparam logic [7:0] RESP_LONG_CRC_FIRST = 8'h00_08;
  // check polynomials, leading term implied
  localparam logic [6:0] CRC7_POLY = 7'h09;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  // token response status field
  localparam logic [2:0] TOKEN_GOOD = 3'h2;
  localparam logic [2:0] TOKEN_BAD = 3'h5;
endpackage

// ---- design/cls_crc_if.sv ----
// Purpose: link between the status block and one check engine
// Assumes: single clock, bits presented one per cycle
// Notes: zero is the running remainder compare
`timescale 1ns/100ps
interface cls_crc_if #(parameter int W = 7);
  logic clr;  // restart the remainder
  logic en;   // fold din in this cycle
  logic din;  // serial bit
  logic zero; // remainder is all zero
  modport eng (input clr, input en, input din, output zero);
  modport user (output clr, output en, output din, input zero);
endinterface

// ---- design/cls_crc.sv ----
// Purpose: serial cyclic check engine, remainder compare to zero
// Assumes: message followed by its check bits is fed in order
// Notes: a good frame leaves an all-zero remainder
`timescale 1ns/100ps
module cls_crc #(
  parameter int W = 7,
  parameter logic [W-1:0] POLY = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // engine side of the link
  cls_crc_if.eng lk
);
  // a one-bit remainder cannot hold any of our polynomials
  if (W < 2) begin : g_chk
    $error("cls_crc: width below 2");
  end

  logic [W-1:0] rem_ff;  // running remainder
  logic [W-1:0] nxt_rem; // next remainder
  logic fb;              // feedback term

  // next remainder: clear wins, then fold one bit
  always_comb begin
    fb = lk.din ^ rem_ff[W-1];
    nxt_rem = rem_ff;
    if (lk.clr) begin
      nxt_rem = '0;
    end else if (lk.en) begin
      nxt_rem = {rem_ff[W-2:0], 1'b0} ^ (fb ? POLY : '0);
    end
  end

  // remainder register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rem_ff <= '0;
    end else begin
      rem_ff <= nxt_rem;
    end
  end

  assign lk.zero = (rem_ff == '0);
endmodule

// ---- design/cls_status.sv ----
// Purpose: read-only card transfer status register with its checks
// Assumes: sequencer strobes are synchronous to clk, one bit a cycle
// Notes: check results land on the edge that takes the frame end bit
// What this block does
// - read-only 8-bit status at address DEh
// - transmit: token CRC status drives bit 4
// - receive: check data block CRC16 into bit 4
// - response CRC7 result drives bit 2
// - response format result drives bit 1
// - check disable skips the CRC7 computation
// - length select picks 48 or 136 bits
`timescale 1ns/100ps
module cls_status (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // special-function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_rd,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // controls from the neighbouring control registers
  input wire logic response_crc_disable,
  input wire logic response_length_select,
  input wire logic data_dir_write,
  // response bit stream
  input wire logic resp_start,
  input wire logic resp_valid,
  input wire logic resp_bit,
  input wire logic resp_end,
  // receive data bit stream, single data line
  input wire logic dat_start,
  input wire logic dat_valid,
  input wire logic dat_bit,
  input wire logic dat_end,
  // token response after a written block
  input wire logic token_valid,
  input wire logic token_start_bit,
  input wire logic [2:0] token_status,
  input wire logic token_end_bit,
  // card and fifo levels
  input wire logic card_busy_in,
  input wire logic fifo_lock_in,
  // status register contents
  output logic [7:0] card_transfer_status
);
  cls_crc_if #(.W(7)) c7 ();
  cls_crc_if #(.W(16)) c16 ();

  // response check engine
  cls_crc #(.W(7), .POLY(cls_pkg::CRC7_POLY)) u_crc7 (
    .clk(clk),
    .rst(rst),
    .lk(c7)
  );
  // data block check engine
  cls_crc #(.W(16), .POLY(cls_pkg::CRC16_POLY)) u_crc16 (
    .clk(clk),
    .rst(rst),
    .lk(c16)
  );

  logic [7:0] sta_ff;     // status flags
  logic [7:0] nxt_sta;
  logic [7:0] rcnt_ff;    // response bit position
  logic [7:0] nxt_rcnt;
  logic rerr_ff;          // response header bit wrong
  logic nxt_rerr;
  logic [15:0] dcnt_ff;   // data bit position, saturating
  logic [15:0] nxt_dcnt;
  logic derr_ff;          // data start bit wrong
  logic nxt_derr;
  logic [7:0] rdata_ff;   // read data
  logic [7:0] nxt_rdata;
  logic [7:0] rlen;       // selected response length
  logic rfeed;            // position is under the check sequence
  logic response_length_select_ok;          // response format verdict
  logic dfmt_ok;          // data frame format verdict
  logic tfmt_ok;          // token format verdict

  // response framing and feed window per length
  always_comb begin
    rlen = response_length_select ? cls_pkg::RESP_LEN_SHORT
                                   : cls_pkg::RESP_LEN_LONG;
    // end bit is never folded in; long form skips its header byte
    if (response_length_select) begin
      rfeed = rcnt_ff < (rlen - 8'h00_01);
    end else begin
      rfeed = (rcnt_ff >= cls_pkg::RESP_LONG_CRC_FIRST) &&
              (rcnt_ff < (rlen - 8'h00_01));
    end
    response_length_select_ok = !rerr_ff && resp_bit &&
              (rcnt_ff == (rlen - 8'h00_01));
    dfmt_ok = !derr_ff && dat_bit && (dcnt_ff != 16'h0000);
    tfmt_ok = !token_start_bit && token_end_bit &&
              ((token_status == cls_pkg::TOKEN_GOOD) ||
               (token_status == cls_pkg::TOKEN_BAD));
  end

  // engine drive; disabled check never folds a bit
  always_comb begin
    c7.clr = resp_start;
    c7.en = resp_valid && rfeed && !response_crc_disable;
    c7.din = resp_bit;
    c16.clr = dat_start;
    // start bit and end bit stay out of the remainder
    c16.en = dat_valid && !dat_end && (dcnt_ff != 16'h0000);
    c16.din = dat_bit;
  end

  // response position and header check
  always_comb begin
    nxt_rcnt = rcnt_ff;
    nxt_rerr = rerr_ff;
    if (resp_start) begin
      nxt_rcnt = 8'h00_00;
      nxt_rerr = 1'b0;
    end else if (resp_valid) begin
      // start and transmission bits must both be low
      if (rcnt_ff < 8'h00_02 && resp_bit) begin
        nxt_rerr = 1'b1;
      end
      // saturate so an overlong frame cannot wrap to a good length
      if (rcnt_ff != 8'h00_FF) begin
        nxt_rcnt = rcnt_ff + 8'h00_01;
      end
    end
  end

  // data position and start bit check
  always_comb begin
    nxt_dcnt = dcnt_ff;
    nxt_derr = derr_ff;
    if (dat_start) begin
      nxt_dcnt = 16'h0000;
      nxt_derr = 1'b0;
    end else if (dat_valid) begin
      if (dcnt_ff == 16'h0000 && dat_bit) begin
        nxt_derr = 1'b1;
      end
      if (dcnt_ff != 16'hFFFF) begin
        nxt_dcnt = dcnt_ff + 16'h0001;
      end
    end
  end

  // status flags; processor writes never reach here
  always_comb begin
    nxt_sta = sta_ff;
    nxt_sta[7:6] = 2'b00;
    nxt_sta[cls_pkg::BIT_BUSY] = card_busy_in;
    nxt_sta[cls_pkg::BIT_FIFO_LOCK] = fifo_lock_in;
    if (resp_valid && resp_end) begin
      nxt_sta[cls_pkg::BIT_RESP_FMT] = response_length_select_ok;
      // with the check off the bit keeps a stale, meaningless value
      if (!response_crc_disable) begin
        nxt_sta[cls_pkg::BIT_RESP_CRC] = c7.zero;
      end
    end
    if (data_dir_write) begin
      if (token_valid) begin
        nxt_sta[cls_pkg::BIT_DATA_FMT] = tfmt_ok;
        if (token_status == cls_pkg::TOKEN_GOOD) begin
          nxt_sta[cls_pkg::BIT_DATA_CRC] = 1'b1;
        end else if (token_status == cls_pkg::TOKEN_BAD) begin
          nxt_sta[cls_pkg::BIT_DATA_CRC] = 1'b0;
        end
      end
    end else if (dat_valid && dat_end) begin
      nxt_sta[cls_pkg::BIT_DATA_FMT] = dfmt_ok;
      nxt_sta[cls_pkg::BIT_DATA_CRC] = c16.zero;
    end
  end

  // read port: one-cycle latency, other addresses read zero
  always_comb begin
    nxt_rdata = 8'h00_00;
    if (sfr_rd && sfr_addr == cls_pkg::STATUS_ADDR) begin
      nxt_rdata = sta_ff;
    end
  end

  // state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sta_ff <= cls_pkg::STATUS_RESET;
      rcnt_ff <= 8'h00_00;
      rerr_ff <= 1'b0;
      dcnt_ff <= 16'h0000;
      derr_ff <= 1'b0;
      rdata_ff <= 8'h00_00;
    end else begin
      sta_ff <= nxt_sta;
      rcnt_ff <= nxt_rcnt;
      rerr_ff <= nxt_rerr;
      dcnt_ff <= nxt_dcnt;
      derr_ff <= nxt_derr;
      rdata_ff <= nxt_rdata;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign card_transfer_status = sta_ff;

  // a status read returns the flags on the next edge
  sequence s_status_read;
    sfr_rd && sfr_addr == cls_pkg::STATUS_ADDR;
  endsequence
  property p_read;
    @(posedge clk) disable iff (rst)
      s_status_read |=> sfr_rdata == $past(sta_ff);
  endproperty
  a_read: assert property (p_read) else $error("bad read data");

  // a lone write leaves flags 4:1 unchanged and bits 7:6 zero
  property p_write;
    @(posedge clk) disable iff (rst)
      sfr_wr && !resp_valid && !dat_valid && !token_valid |=>
        sta_ff[4:1] == $past(sta_ff[4:1]) && sta_ff[7:6] == 2'b00;
  endproperty
  a_write: assert property (p_write) else $error("write moved a flag");

  property p_token;
    @(posedge clk) disable iff (rst)
      data_dir_write && token_valid &&
      token_status == cls_pkg::TOKEN_GOOD |=> sta_ff[4];
  endproperty
  a_token: assert property (p_token) else $error("good token lost");

  property p_dcrc;
    @(posedge clk) disable iff (rst)
      !data_dir_write && dat_valid && dat_end |=>
        sta_ff[4] == $past(c16.zero);
  endproperty
  a_dcrc: assert property (p_dcrc) else $error("data crc flag wrong");

  // response end: engine verdict appears one edge later
  sequence s_resp_end;
    resp_valid && resp_end && !response_crc_disable;
  endsequence
  property p_rcrc;
    @(posedge clk) disable iff (rst)
      s_resp_end |=> sta_ff[2] == $past(c7.zero);
  endproperty
  a_rcrc: assert property (p_rcrc) else $error("resp crc flag wrong");

  property p_response_length_select;
    @(posedge clk) disable iff (rst)
      resp_valid && resp_end && resp_bit && !rerr_ff &&
      rcnt_ff == rlen - 8'h00_01 |=> sta_ff[1];
  endproperty
  a_response_length_select: assert property (p_response_length_select) else $error("good format missed");

  property p_disable;
    @(posedge clk) disable iff (rst)
      response_crc_disable |-> !c7.en ##1 $stable(sta_ff[2]);
  endproperty
  a_disable: assert property (p_disable) else $error("crc7 ran");

  property p_short;
    @(posedge clk) disable iff (rst)
      resp_valid && resp_end && response_length_select &&
      rcnt_ff == cls_pkg::RESP_LEN_LONG - 8'h00_01 |=> !sta_ff[1];
  endproperty
  a_short: assert property (p_short) else $error("length ignored");

  property p_levels;
    @(posedge clk) disable iff (rst)
      card_busy_in && fifo_lock_in |=> sta_ff[5] && sta_ff[0];
  endproperty
  a_levels: assert property (p_levels) else $error("level not shown");
endmodule

// ---- verification/cls_card_model.sv ----
// Purpose: card side model driving response, data and token streams
// Assumes: one bit per clk, every change launched at a rising edge
// Notes: idle stream lines toggle so no stale bit looks valid
`timescale 1ns/100ps
module cls_card_model (
  // clock
  input wire logic clk,
  // response stream
  output logic resp_start,
  output logic resp_valid,
  output logic resp_bit,
  output logic resp_end,
  // data stream
  output logic dat_start,
  output logic dat_valid,
  output logic dat_bit,
  output logic dat_end,
  // token fields
  output logic token_valid,
  output logic token_start_bit,
  output logic [2:0] token_status,
  output logic token_end_bit
);
  logic [135:0] m; // frame image, bit 0 goes first
  initial begin
    {resp_start, resp_valid, resp_bit, resp_end} = 4'h0;
    {dat_start, dat_valid, dat_bit, dat_end} = 4'h0;
    {token_valid, token_start_bit, token_status, token_end_bit} = 6'h00;
  end
  // msb-first remainder; appended, it leaves an all-zero check
  function automatic logic [15:0] crc(int lo, int hi, int w,
                                      logic [15:0] p);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = lo; i <= hi; i++) begin
      r = (r << 1) ^ ((r[w-1] ^ m[i]) ? p : 16'h0000);
    end
    return r & 16'((32'h1 << w) - 1);
  endfunction
  // start pulse, then n bits; the other stream toggles meanwhile
  task automatic frame(bit rsp, int n);
    @(posedge clk);
    resp_start <= rsp;
    dat_start <= !rsp;
    @(posedge clk);
    {resp_start, dat_start} <= 2'h0;
    for (int i = 0; i < n; i++) begin
      resp_valid <= rsp;
      resp_end <= rsp && i == n - 1;
      resp_bit <= rsp ? m[i] : ~resp_bit;
      dat_valid <= !rsp;
      dat_end <= !rsp && i == n - 1;
      dat_bit <= rsp ? ~dat_bit : m[i];
      @(posedge clk);
    end
    {resp_valid, resp_end, dat_valid, dat_end} <= 4'h0;
    resp_bit <= ~resp_bit;
    dat_bit <= ~dat_bit;
  endtask
  // response of 48 or 136 bits, check over the selected span
  task automatic send_resp(bit lng, bit bad_crc, bit bad_end);
    int n;
    int hi;
    logic [15:0] r;
    n = lng ? 136 : 48;
    hi = n - 9;
    for (int i = 0; i < 136; i++) m[i] = i > 1 && i % 3 == 0;
    r = crc(lng ? 8 : 0, hi, 7, 16'h0009);
    for (int k = 0; k < 7; k++) m[hi+1+k] = r[6-k] ^ (bad_crc && k == 0);
    m[n-1] = !bad_end;
    frame(1'b1, n);
  endtask
  // data block: start bit, 16 data bits, 16 check bits, end bit
  task automatic send_dat(bit bad_crc, bit bad_end);
    logic [15:0] r;
    for (int i = 0; i < 136; i++) m[i] = i > 0 && i % 3 == 0;
    r = crc(1, 16, 16, 16'h1021);
    for (int k = 0; k < 16; k++) m[17+k] = r[15-k] ^ (bad_crc && k == 0);
    m[33] = !bad_end;
    frame(1'b0, 34);
  endtask
  // token after a written block; fields garbled once released
  task automatic send_tok(logic [2:0] st, bit bad_end);
    @(posedge clk);
    token_valid <= 1'b1;
    token_start_bit <= 1'b0;
    token_status <= st;
    token_end_bit <= !bad_end;
    @(posedge clk);
    token_valid <= 1'b0;
    token_status <= ~st;
    token_end_bit <= bad_end;
  endtask
endmodule

// ---- verification/card_link_status_flags_test.sv ----
// Purpose: self-checking bench of the card status register
// Assumes: card model drives all frame streams
// Notes: outside the register test, status bits are judged masked to the field under test
`timescale 1ns/100ps
module card_link_status_flags_test;
  logic clk = 1'b0;
  logic rst, sfr_rd, sfr_wr, response_crc_disable, response_length_select;
  logic data_dir_write, card_busy_in, fifo_lock_in;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, card_transfer_status;
  logic resp_start, resp_valid, resp_bit, resp_end;
  logic dat_start, dat_valid, dat_bit, dat_end;
  logic token_valid, token_start_bit, token_end_bit;
  logic [2:0] token_status;
  int err_total = 0; // mismatches
  int n_tests = 0; // comparisons
  always #2 clk = ~clk;
  cls_status i_cls_status (.clk(clk), .rst(rst), .sfr_addr(sfr_addr),
    .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .response_crc_disable(response_crc_disable),
    .response_length_select(response_length_select),
    .data_dir_write(data_dir_write), .resp_start(resp_start),
    .resp_valid(resp_valid), .resp_bit(resp_bit), .resp_end(resp_end),
    .dat_start(dat_start), .dat_valid(dat_valid), .dat_bit(dat_bit),
    .dat_end(dat_end), .token_valid(token_valid),
    .token_start_bit(token_start_bit), .token_status(token_status),
    .token_end_bit(token_end_bit), .card_busy_in(card_busy_in),
    .fifo_lock_in(fifo_lock_in),
    .card_transfer_status(card_transfer_status));
  cls_card_model i_cls_card_model (.clk(clk), .resp_start(resp_start),
    .resp_valid(resp_valid), .resp_bit(resp_bit), .resp_end(resp_end),
    .dat_start(dat_start), .dat_valid(dat_valid), .dat_bit(dat_bit),
    .dat_end(dat_end), .token_valid(token_valid),
    .token_start_bit(token_start_bit), .token_status(token_status),
    .token_end_bit(token_end_bit));
  // one compare for every byte-wide result
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // read strobe taken at one edge, data judged just after that same edge
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge clk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1 chk("sfr_rdata", exp, sfr_rdata);
  endtask
  task automatic ctl(logic dis, logic sel, logic dir);
    @(posedge clk);
    response_crc_disable <= dis;
    response_length_select <= sel;
    data_dir_write <= dir;
  endtask
  // write attempt, levels, unmapped read
  task automatic t_reg;
    @(posedge clk);
    {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, 8'hde, 8'hff};
    @(posedge clk);
    sfr_wr <= 1'b0;
    {card_busy_in, fifo_lock_in} <= 2'h3;
    #1 chk("status", 8'h00, card_transfer_status);
    rd(8'hde, 8'h21);
    rd(8'hdd, 8'h00);
    {card_busy_in, fifo_lock_in} <= 2'h0;
    rd(8'hde, 8'h00);
    $display("test reg done");
  endtask
  // both lengths: good, bad check, bad end bit
  task automatic t_resp;
    for (int l = 0; l < 2; l++) begin
      ctl(1'b0, l == 0, 1'b0);
      i_cls_card_model.send_resp(l == 1, 1'b0, 1'b0);
      #1 chk("resp", 8'h06, card_transfer_status & 8'h06);
      i_cls_card_model.send_resp(l == 1, 1'b1, 1'b0);
      #1 chk("resp", 8'h02, card_transfer_status & 8'h06);
      i_cls_card_model.send_resp(l == 1, 1'b0, 1'b1);
      #1 chk("resp", 8'h04, card_transfer_status & 8'h06);
    end
    i_cls_card_model.send_resp(1'b0, 1'b0, 1'b0);
    #1 chk("resp len", 8'h00, card_transfer_status & 8'h02);
    // long frame while the short form is selected must fail format
    ctl(1'b0, 1'b1, 1'b0);
    i_cls_card_model.send_resp(1'b1, 1'b0, 1'b0);
    #1 chk("resp len", 8'h00, card_transfer_status & 8'h02);
    $display("test resp done");
  endtask
  // disabled check leaves bit 2 alone; software must ignore it
  task automatic t_response_crc_disable;
    ctl(1'b0, 1'b1, 1'b0);
    i_cls_card_model.send_resp(1'b0, 1'b0, 1'b0);
    ctl(1'b1, 1'b1, 1'b0);
    i_cls_card_model.send_resp(1'b0, 1'b1, 1'b0);
    #1 chk("crc off", 8'h06, card_transfer_status & 8'h06);
    $display("test response_crc_disable done");
  endtask
  // receive block: good, bad check, bad end bit
  task automatic t_data;
    ctl(1'b0, 1'b1, 1'b0);
    i_cls_card_model.send_dat(1'b0, 1'b0);
    #1 chk("data", 8'h18, card_transfer_status & 8'h18);
    i_cls_card_model.send_dat(1'b1, 1'b0);
    #1 chk("data", 8'h08, card_transfer_status & 8'h18);
    i_cls_card_model.send_dat(1'b0, 1'b1);
    #1 chk("data", 8'h10, card_transfer_status & 8'h18);
    $display("test data done");
  endtask
  // token codes good and bad, then a broken end bit
  task automatic t_token;
    ctl(1'b0, 1'b1, 1'b1);
    i_cls_card_model.send_tok(3'h2, 1'b0);
    @(posedge clk);
    #1 chk("token", 8'h18, card_transfer_status & 8'h18);
    i_cls_card_model.send_tok(3'h5, 1'b0);
    @(posedge clk);
    #1 chk("token", 8'h08, card_transfer_status & 8'h18);
    i_cls_card_model.send_tok(3'h2, 1'b1);
    @(posedge clk);
    #1 chk("token", 8'h10, card_transfer_status & 8'h18);
    // unknown status code: format fails, check bit keeps its value
    i_cls_card_model.send_tok(3'h7, 1'b0);
    @(posedge clk);
    #1 chk("token", 8'h10, card_transfer_status & 8'h18);
    // clearing write while flags are set must not move them
    @(posedge clk);
    {sfr_wr, sfr_addr, sfr_wdata} <= {1'b1, 8'hde, 8'h00};
    @(posedge clk);
    sfr_wr <= 1'b0;
    #1 chk("status", 8'h16, card_transfer_status & 8'h1e);
    $display("test token done");
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {sfr_rd, sfr_wr, sfr_addr, sfr_wdata} = 18'h0_0000;
    {response_crc_disable, response_length_select, data_dir_write} = 3'h0;
    {card_busy_in, fifo_lock_in} = 2'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reg;
    t_resp;
    t_response_crc_disable;
    t_data;
    t_token;
    stop_test;
  end
  // hang guard
  initial begin
    #200000;
    err_total++;
    stop_test;
  end
endmodule
